// ==== rtl/gauge_twowire_pkg.sv ====
// Function
// R01 - act only as target, answer fixed 7-bit address, write and read forms
// R02 - on address match drive acknowledge in the clock after direction bit
// R03 - work at any serial clock rate up to the maximum, no speed setting
// R04 - data line is input when receiving, open-drain low or released when sending
// R05 - one bit per clock; data changes while clock high mean START or STOP
// R06 - detect START as data falling and STOP as data rising while clock high
// R07 - repeated START ends current transaction and begins a new one
// R08 - receiver acknowledges by holding data low across the ninth clock
// R09 - bytes are eight bits, most significant first, then acknowledge bit
// R10 - multibyte registers keep high byte at even address and send it first
// R11 - direction bit 0 means write, 1 means read
// R12 - while idle keep watching for START followed by own address
// R13 - write sends address, pointer byte, then data stored from the pointer
// R14 - pointer increments after each received data byte
// R15 - discard write bytes once the pointer has run past the write limit
// R16 - register write takes effect only when both bytes are delivered
// R17 - writes to read-only addresses are discarded
// R18 - partial bytes and unacknowledged bytes are never stored
// R19 - master ends a write with STOP or repeated START after last acknowledge
// R20 - read uses pointer write, repeated START, then target drives data line
// R21 - read returns from pointer, increments, and all-ones past top address
// R22 - master ends read with not-acknowledge; target then releases data line
// R23 - master must read both register bytes within one transaction
// R24 - accesses are valid only with all sixteen bits; early writes ignored
// R25 - soft-reset value to command register resets device and is not acknowledged
// R26 - both lines low long enough gives sleep; any rising edge wakes
// R27 - on address mismatch keep data line released until next START
package gauge_twowire_pkg;
  localparam logic [6:0]  TARGET_ADDR  = 7'h36;
  localparam logic [7:0]  WRITE_LIMIT  = 8'h4F;
  localparam logic [7:0]  TOP_ADDR     = 8'hFF;
  localparam logic [7:0]  FILL_BYTE    = 8'hFF;
  localparam logic [7:0]  MODE_ADDR    = 8'h06;
  localparam logic [7:0]  COMP_ADDR    = 8'h0C;
  localparam logic [7:0]  CMD_ADDR     = 8'hFE;
  localparam logic [15:0] SRST_VALUE   = 16'h0054;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam int unsigned SLEEP_TIME_MS = 2500;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam longint unsigned SLEEP_CYCLES_L =
    (64'(SLEEP_TIME_MS) * 64'h00000000000F4240) / 64'(CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR      = 4'h3,
    ST_PTR_ACK  = 4'h4,
    ST_WDATA    = 4'h5,
    ST_WACK     = 4'h6,
    ST_RDATA    = 4'h7,
    ST_RACK     = 4'h8,
    ST_IGNORE   = 4'h9
  } link_state_t;

  // register pairs that accept writes; everything else is read-only
  function automatic logic is_writable(input logic [7:0] a);
    logic [7:0] even;
    even = {a[7:1], 1'b0};
    return (even == MODE_ADDR) || (even == COMP_ADDR) || (even == CMD_ADDR);
  endfunction
endpackage

// ==== rtl/gauge_twowire_target_port.sv ====
module gauge_twowire_target_port #(
  parameter int unsigned SLEEP_CYCLES =
    int'(gauge_twowire_pkg::SLEEP_CYCLES_L)
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        link_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             wr_valid_o,
  output logic [7:0]       wr_addr_o,
  output logic [15:0]      wr_data_o,
  output logic [7:0]       rd_addr_o,
  input  wire logic [7:0]  rd_data_i,
  output logic             soft_reset_o,
  output logic             sleep_o
);
  // ---------------- link domain: pin synchronisers ----------------
  logic        scl_m_q, scl_s_q, scl_p_q;
  logic        sda_m_q, sda_s_q, sda_p_q;
  logic        start_w, stop_w, rise_w, fall_w;

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // oversampled edges, so no speed setting is needed below the rate limit
  assign rise_w  = scl_s_q & ~scl_p_q; // R03 R05
  assign fall_w  = ~scl_s_q & scl_p_q;
  assign start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q; // R06
  assign stop_w  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q; // R06

  // ---------------- link domain: byte engine ----------------
  gauge_twowire_pkg::link_state_t state_q;
  logic [2:0]  cnt_q;
  logic        got_q;
  logic [7:0]  sr_q;
  logic [7:0]  tx_q;
  logic        oe_q;
  logic        rw_q;
  logic        nak_q;
  logic [7:0]  ptr_q;
  logic        over_q;
  logic        past_q;
  logic [7:0]  hi_q;
  logic        hi_ok_q;
  logic [7:0]  rdbuf_q;
  logic        rd_pend_q;
  logic        rd_req_tgl_q;
  logic [7:0]  rd_req_addr_q;
  logic        wr_tgl_q;
  logic [7:0]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic        srst_tgl_q;
  logic        ack_m_q, ack_s_q, ack_p_q;
  logic        rsp_tgl_q;
  logic [7:0]  rsp_data_q;

  logic        byte_end_w, addr_hit_w, wr_end_w, wr_keep_w, srst_hit_w;
  logic        rd_load_w;
  logic [7:0]  load_byte_w;
  logic [2:0]  bit_idx_w;

  assign byte_end_w  = fall_w & got_q;
  assign addr_hit_w  = sr_q[7:1] == gauge_twowire_pkg::TARGET_ADDR; // R01
  // only a full eight-bit byte ends here, before its acknowledge slot; cut bytes never reach storage
  assign wr_end_w    = (state_q == gauge_twowire_pkg::ST_WDATA) & byte_end_w; // R18
  assign wr_keep_w   = ~over_q & gauge_twowire_pkg::is_writable(ptr_q);
  assign srst_hit_w  = wr_end_w & ptr_q[0] & hi_ok_q & wr_keep_w
                     & ({hi_q, sr_q} == gauge_twowire_pkg::SRST_VALUE)
                     & ({ptr_q[7:1], 1'b0} == gauge_twowire_pkg::CMD_ADDR);
  assign rd_load_w   = fall_w & (((state_q == gauge_twowire_pkg::ST_ADDR_ACK)
                     & rw_q) | ((state_q == gauge_twowire_pkg::ST_RACK)
                     & ~nak_q));
  assign load_byte_w = past_q ? gauge_twowire_pkg::FILL_BYTE : rdbuf_q; // R21
  assign bit_idx_w   = gauge_twowire_pkg::LAST_BIT - cnt_q; // R09

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= gauge_twowire_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
      got_q   <= 1'b0;
      sr_q    <= 8'h00;
      tx_q    <= 8'h00;
      oe_q    <= 1'b0;
      rw_q    <= 1'b0;
      nak_q   <= 1'b0;
    end else if (start_w) begin
      state_q <= gauge_twowire_pkg::ST_ADDR; // R07 R12
      cnt_q   <= 3'h0;
      got_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else if (stop_w) begin
      state_q <= gauge_twowire_pkg::ST_IDLE; // R19 R22
      got_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      unique case (state_q)
        gauge_twowire_pkg::ST_IDLE, gauge_twowire_pkg::ST_IGNORE: begin
          oe_q <= 1'b0; // R27
        end
        gauge_twowire_pkg::ST_ADDR, gauge_twowire_pkg::ST_PTR,
        gauge_twowire_pkg::ST_WDATA: begin
          if (rise_w) begin
            sr_q  <= {sr_q[6:0], sda_s_q}; // R04 R09
            cnt_q <= cnt_q + 3'h1;
            got_q <= cnt_q == gauge_twowire_pkg::LAST_BIT;
          end else if (byte_end_w) begin
            got_q <= 1'b0;
            cnt_q <= 3'h0;
            if (state_q == gauge_twowire_pkg::ST_ADDR) begin
              if (addr_hit_w) begin
                state_q <= gauge_twowire_pkg::ST_ADDR_ACK;
                oe_q    <= 1'b1; // R02 R08
                rw_q    <= sr_q[0]; // R11
              end else begin
                state_q <= gauge_twowire_pkg::ST_IGNORE; // R27
              end
            end else if (state_q == gauge_twowire_pkg::ST_PTR) begin
              state_q <= gauge_twowire_pkg::ST_PTR_ACK;
              oe_q    <= 1'b1; // R13
            end else begin
              state_q <= gauge_twowire_pkg::ST_WACK;
              oe_q    <= ~srst_hit_w; // R25
            end
          end
        end
        gauge_twowire_pkg::ST_ADDR_ACK: begin
          if (fall_w) begin
            if (rw_q) begin
              state_q <= gauge_twowire_pkg::ST_RDATA; // R20
              tx_q    <= load_byte_w;
              oe_q    <= ~load_byte_w[gauge_twowire_pkg::LAST_BIT]; // R10
            end else begin
              state_q <= gauge_twowire_pkg::ST_PTR;
              oe_q    <= 1'b0;
            end
          end
        end
        gauge_twowire_pkg::ST_PTR_ACK, gauge_twowire_pkg::ST_WACK: begin
          if (fall_w) begin
            state_q <= gauge_twowire_pkg::ST_WDATA; // R13
            oe_q    <= 1'b0;
          end
        end
        gauge_twowire_pkg::ST_RDATA: begin
          if (rise_w) begin
            cnt_q <= cnt_q + 3'h1;
            got_q <= cnt_q == gauge_twowire_pkg::LAST_BIT;
          end else if (byte_end_w) begin
            got_q   <= 1'b0;
            cnt_q   <= 3'h0;
            state_q <= gauge_twowire_pkg::ST_RACK;
            oe_q    <= 1'b0; // R20
          end else if (fall_w) begin
            oe_q <= ~tx_q[bit_idx_w]; // R04
          end
        end
        gauge_twowire_pkg::ST_RACK: begin
          if (rise_w) begin
            nak_q <= sda_s_q; // R08
          end else if (fall_w) begin
            if (nak_q) begin
              state_q <= gauge_twowire_pkg::ST_IGNORE; // R22
              oe_q    <= 1'b0;
            end else begin
              state_q <= gauge_twowire_pkg::ST_RDATA;
              tx_q    <= load_byte_w;
              oe_q    <= ~load_byte_w[gauge_twowire_pkg::LAST_BIT];
            end
          end
        end
        default: begin
          state_q <= gauge_twowire_pkg::ST_IDLE;
          oe_q    <= 1'b0;
        end
      endcase
    end
  end

  // pointer, pairing of written bytes and read prefetch
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q      <= 8'h00;
      over_q     <= 1'b0;
      past_q     <= 1'b0;
      hi_q       <= 8'h00;
      hi_ok_q    <= 1'b0;
      wr_tgl_q   <= 1'b0;
      wr_addr_q  <= 8'h00;
      wr_data_q  <= 16'h0000;
      srst_tgl_q <= 1'b0;
      rd_pend_q  <= 1'b0;
    end else if (start_w || stop_w) begin
      hi_ok_q <= 1'b0; // R24
    end else begin
      if ((state_q == gauge_twowire_pkg::ST_PTR) && byte_end_w) begin
        ptr_q   <= sr_q; // R13
        over_q  <= 1'b0;
        past_q  <= 1'b0;
        hi_ok_q <= 1'b0;
      end
      if (wr_end_w) begin
        if (!ptr_q[0]) begin
          hi_q    <= sr_q; // R10
          hi_ok_q <= wr_keep_w; // R15 R17
        end else begin
          hi_ok_q <= 1'b0;
          if (hi_ok_q && wr_keep_w && !srst_hit_w) begin
            wr_tgl_q  <= ~wr_tgl_q; // R16
            wr_addr_q <= {ptr_q[7:1], 1'b0};
            wr_data_q <= {hi_q, sr_q};
          end
          if (srst_hit_w) begin
            srst_tgl_q <= ~srst_tgl_q; // R25
          end
        end
        ptr_q <= ptr_q + 8'h01; // R14
        if (ptr_q == gauge_twowire_pkg::WRITE_LIMIT) begin
          over_q <= 1'b1; // R15
        end
      end
      if ((state_q == gauge_twowire_pkg::ST_ADDR) && byte_end_w
          && addr_hit_w && sr_q[0]) begin
        rd_pend_q <= 1'b1;
      end else if (rd_load_w) begin
        ptr_q     <= ptr_q + 8'h01; // R21
        past_q    <= past_q | (ptr_q == gauge_twowire_pkg::TOP_ADDR);
        rd_pend_q <= 1'b1;
      end else if (rd_pend_q && (rd_req_tgl_q == ack_s_q)) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // one outstanding read request; the reply lands in rdbuf_q long before use
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_req_tgl_q  <= 1'b0;
      rd_req_addr_q <= 8'h00;
      ack_m_q       <= 1'b0;
      ack_s_q       <= 1'b0;
      ack_p_q       <= 1'b0;
      rdbuf_q       <= 8'h00;
    end else begin
      ack_m_q <= rsp_tgl_q;
      ack_s_q <= ack_m_q;
      ack_p_q <= ack_s_q;
      if (rd_pend_q && (rd_req_tgl_q == ack_s_q) && !rd_load_w) begin
        rd_req_tgl_q  <= ~rd_req_tgl_q;
        rd_req_addr_q <= ptr_q;
      end
      if (ack_s_q != ack_p_q) begin
        rdbuf_q <= rsp_data_q;
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      sda_oe_o <= oe_q; // R04
      sda_o    <= 1'b0;
    end
  end

  // ---------------- system domain ----------------
  logic        rq_m_q, rq_s_q, rq_p_q, rd_cap_q;
  logic        wt_m_q, wt_s_q, wt_p_q;
  logic        sr_m_q, sr_s_q, sr_p_q;
  logic        cscl_m_q, cscl_s_q, csda_m_q, csda_s_q;
  logic [31:0] idle_cnt_q;

  // addresses and data are held stable by the link side until the next toggle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rq_m_q     <= 1'b0;
      rq_s_q     <= 1'b0;
      rq_p_q     <= 1'b0;
      rd_cap_q   <= 1'b0;
      rd_addr_o  <= 8'h00;
      rsp_tgl_q  <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      rq_m_q   <= rd_req_tgl_q;
      rq_s_q   <= rq_m_q;
      rq_p_q   <= rq_s_q;
      rd_cap_q <= rq_s_q != rq_p_q;
      if (rq_s_q != rq_p_q) begin
        rd_addr_o <= rd_req_addr_q;
      end
      if (rd_cap_q) begin
        rsp_data_q <= rd_data_i;
        rsp_tgl_q  <= ~rsp_tgl_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wt_m_q       <= 1'b0;
      wt_s_q       <= 1'b0;
      wt_p_q       <= 1'b0;
      sr_m_q       <= 1'b0;
      sr_s_q       <= 1'b0;
      sr_p_q       <= 1'b0;
      wr_valid_o   <= 1'b0;
      wr_addr_o    <= 8'h00;
      wr_data_o    <= 16'h0000;
      soft_reset_o <= 1'b0;
    end else begin
      wt_m_q       <= wr_tgl_q;
      wt_s_q       <= wt_m_q;
      wt_p_q       <= wt_s_q;
      sr_m_q       <= srst_tgl_q;
      sr_s_q       <= sr_m_q;
      sr_p_q       <= sr_s_q;
      wr_valid_o   <= wt_s_q != wt_p_q; // R16
      soft_reset_o <= sr_s_q != sr_p_q; // R25
      if (wt_s_q != wt_p_q) begin
        wr_addr_o <= wr_addr_q;
        wr_data_o <= wr_data_q;
      end
    end
  end

  // sleep only flags the rest of the device; the port itself keeps running
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cscl_m_q   <= 1'b1;
      cscl_s_q   <= 1'b1;
      csda_m_q   <= 1'b1;
      csda_s_q   <= 1'b1;
      idle_cnt_q <= 32'h00000000;
      sleep_o    <= 1'b0;
    end else begin
      cscl_m_q <= scl_i;
      cscl_s_q <= cscl_m_q;
      csda_m_q <= sda_i;
      csda_s_q <= csda_m_q;
      if (cscl_s_q || csda_s_q) begin
        idle_cnt_q <= 32'h00000000;
        sleep_o    <= 1'b0; // R26
      end else if (idle_cnt_q >= SLEEP_CYCLES - 1) begin
        sleep_o <= 1'b1; // R26
      end else begin
        idle_cnt_q <= idle_cnt_q + 32'h00000001;
      end
    end
  end

  // ---------------- checks ----------------
  sequence addr_byte_s;
    (state_q == gauge_twowire_pkg::ST_ADDR) && byte_end_w && !start_w
      && !stop_w;
  endsequence

  sequence read_end_s;
    (state_q == gauge_twowire_pkg::ST_RACK) && fall_w && nak_q && !start_w
      && !stop_w;
  endsequence

  addr_ack_drive_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R02
    addr_byte_s and addr_hit_w |=> oe_q ##1 sda_oe_o)
    else $error("no acknowledge after own address");
  mismatch_quiet_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R27
    addr_byte_s and !addr_hit_w |=> !oe_q ##1 !sda_oe_o)
    else $error("data line driven after foreign address");
  start_restart_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R07
    start_w |=> (state_q == gauge_twowire_pkg::ST_ADDR) && !oe_q)
    else $error("start did not restart address phase");
  stop_release_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R22
    stop_w |=> !oe_q ##1 !sda_oe_o)
    else $error("data line held after stop");
  read_release_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R22
    read_end_s |=> (state_q == gauge_twowire_pkg::ST_IGNORE) && !oe_q)
    else $error("target kept line after not-acknowledge");
  master_ack_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R20
    (state_q == gauge_twowire_pkg::ST_RACK) |-> !oe_q)
    else $error("target drove master acknowledge slot");
  limit_guard_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R15
    $changed(wr_tgl_q) |-> wr_addr_q < gauge_twowire_pkg::WRITE_LIMIT
      || wr_addr_q == gauge_twowire_pkg::CMD_ADDR)
    else $error("write committed beyond limit");
  soft_nak_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R25
    srst_hit_w && !start_w && !stop_w |=> !oe_q && $changed(srst_tgl_q))
    else $error("soft reset byte acknowledged");
  ptr_step_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) // R14
    wr_end_w && !start_w && !stop_w |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not step after byte");
  wr_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
    wr_valid_o |-> !wr_addr_o[0] ##1 !wr_valid_o)
    else $error("write strobe malformed");
  sleep_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R26
    sleep_o && (cscl_s_q || csda_s_q) |=> !sleep_o)
    else $error("no wake on bus activity");
endmodule

// ==== testbench/twowire_master_model.sv ====
module twowire_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // half scl period in clk_i cycles; 25 gives 400 kHz
  int h = 25;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // from idle, or as a repeated start in mid-transaction
  task automatic start_cond();
    if (scl_o == 1'b0) begin
      sda_pull_o = 1'b0;
      wait_cyc(h - h / 2);
      scl_o = 1'b1;
      wait_cyc(h);
    end
    sda_pull_o = 1'b1;
    wait_cyc(h);
    scl_o = 1'b0;
    wait_cyc(h / 2);
  endtask
  task automatic stop_cond();
    if (scl_o == 1'b0) begin
      sda_pull_o = 1'b1;
      wait_cyc(h - h / 2);
      scl_o = 1'b1;
      wait_cyc(h);
    end
    sda_pull_o = 1'b0;
    wait_cyc(h);
  endtask
  // wake from sleep: scl rises while data stays low
  task automatic raise_scl();
    scl_o = 1'b1;
  endtask
  // data moves only while scl is low, so no false start or stop
  task automatic bit_xfer(input logic b, output logic r);
    sda_pull_o = ~b;
    wait_cyc(h - h / 2);
    scl_o = 1'b1;
    wait_cyc(h - 1);
    r = sda_i;
    wait_cyc(1);
    scl_o = 1'b0;
    wait_cyc(h / 2);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic ack_m);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack_m, r);
  endtask
endmodule

// ==== testbench/gauge_twowire_target_port_bench.sv ====
module gauge_twowire_target_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SLEEP_N = 64;
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        nrst;
  logic        scl;
  logic        sda_pull;
  logic        sda_w;
  logic        dut_sda;
  logic        dut_sda_oe;
  logic        wr_valid;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        soft_reset;
  logic        sleep;
  logic [7:0]  last_addr;
  logic [15:0] last_data;
  int          err_total = 0;
  int          total_checks = 0;
  int          wr_cnt = 0;
  int          srst_cnt = 0;

  always #25 clk = ~clk;
  // link clock offset so its edges never line up with clk
  initial begin
    #13;
    forever #80 link_clk = ~link_clk;
  end

  function automatic logic [7:0] mem_byte(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction

  // open-drain wire with pull-up
  assign sda_w = ~(sda_pull | (dut_sda_oe & ~dut_sda));
  assign rd_data = mem_byte(rd_addr);

  gauge_twowire_target_port #(.SLEEP_CYCLES(SLEEP_N)) u_dut (
    .clk_i(clk), .nrst_i(nrst), .link_clk_i(link_clk), .scl_i(scl),
    .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_sda_oe),
    .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .soft_reset_o(soft_reset), .sleep_o(sleep)
  );

  twowire_master_model u_master (
    .clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull)
  );

  always @(negedge clk) begin
    if (wr_valid === 1'b1) begin
      wr_cnt++;
      last_addr = wr_addr;
      last_data = wr_data;
    end
    if (soft_reset === 1'b1) begin
      srst_cnt++;
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    u_master.wr_byte(d, a);
    chk({15'h0, a}, {15'h0, exp_ack});
  endtask

  task automatic t_write(input int hc, input logic [7:0] a,
                         input logic [15:0] d);
    int n0;
    n0 = wr_cnt;
    u_master.h = hc;
    u_master.start_cond();
    send(8'h6C, 1'b1);
    send(a, 1'b1);
    send(d[15:8], 1'b1);
    send(d[7:0], 1'b1);
    u_master.stop_cond();
    u_master.wait_cyc(20);
    chk(16'(wr_cnt - n0), 16'h0001);
    chk({8'h00, last_addr}, {8'h00, a});
    chk(last_data, d);
    u_master.h = 25;
    $display("write test done");
  endtask

  task automatic t_refused();
    int n0;
    n0 = wr_cnt;
    u_master.start_cond();
    send(8'h70, 1'b0);
    send(8'h0C, 1'b0);
    u_master.stop_cond();
    u_master.start_cond();
    send(8'h6C, 1'b1);
    send(8'h04, 1'b1);
    send(8'h12, 1'b1);
    send(8'h34, 1'b1);
    u_master.stop_cond();
    u_master.start_cond();
    send(8'h6C, 1'b1);
    send(8'h06, 1'b1);
    send(8'h40, 1'b1);
    u_master.start_cond();
    send(8'h6C, 1'b1);
    send(8'h0C, 1'b1);
    send(8'h12, 1'b1);
    send(8'h34, 1'b1);
    u_master.stop_cond();
    u_master.wait_cyc(20);
    chk(16'(wr_cnt - n0), 16'h0001);
    chk({8'h00, last_addr}, 16'h000C);
    chk(last_data, 16'h1234);
    $display("refused write test done");
  endtask

  task automatic t_read(input logic [7:0] p);
    logic [7:0] got;
    logic [8:0] s;
    logic [7:0] exp;
    u_master.start_cond();
    send(8'h6C, 1'b1);
    send(p, 1'b1);
    u_master.start_cond();
    send(8'h6D, 1'b1);
    for (int i = 0; i < 4; i++) begin
      u_master.rd_byte(got, i != 3);
      s = {1'b0, p} + 9'(i);
      exp = s[8] ? 8'hFF : mem_byte(s[7:0]);
      chk({8'h00, got}, {8'h00, exp});
    end
    u_master.stop_cond();
    u_master.wait_cyc(10);
    chk({15'h0, dut_sda_oe}, 16'h0000);
    chk({15'h0, dut_sda}, 16'h0000);
    $display("read test done");
  endtask

  task automatic t_soft_reset();
    int n0;
    int s0;
    n0 = wr_cnt;
    s0 = srst_cnt;
    u_master.start_cond();
    send(8'h6C, 1'b1);
    send(8'hFE, 1'b1);
    send(8'h00, 1'b1);
    send(8'h54, 1'b0);
    u_master.stop_cond();
    u_master.wait_cyc(20);
    chk(16'(srst_cnt - s0), 16'h0001);
    chk(16'(wr_cnt - n0), 16'h0000);
    $display("soft reset test done");
  endtask

  task automatic t_sleep();
    u_master.start_cond();
    u_master.wait_cyc(40);
    chk({15'h0, sleep}, 16'h0000);
    u_master.wait_cyc(60);
    chk({15'h0, sleep}, 16'h0001);
    u_master.raise_scl();
    u_master.wait_cyc(6);
    chk({15'h0, sleep}, 16'h0000);
    u_master.stop_cond();
    $display("sleep test done");
  endtask

  // the whole run needs about 1.2 ms
  initial begin
    #4000000;
    err_total++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    // reset is asynchronous, so the slow link clock needs no edge inside it
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    u_master.wait_cyc(20);
    t_write(25, 8'h0C, 16'h9700);
    t_write(100, 8'h06, 16'h4000);
    t_refused();
    t_read(8'h0C);
    t_read(8'hFE);
    t_soft_reset();
    t_sleep();
    stop_test();
  end
endmodule
